/* hw/input_filter.sv */
`timescale 1ns/100ps
module input_filter (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    input wire logic pin_i,
    output logic level_o
);
    logic [1:0] run_reg;
    logic [1:0] run_next;
    logic level_next;
    wire differs = pin_i != level_o;
    // Level changes after pin steady beyond two count clocks
    assign run_next = !differs ? 2'h0 :
        (tick_i ? run_reg + 2'h1 : run_reg); // R19
    assign level_next = (differs && tick_i &&
        run_reg == timer_ctl_pkg::FILTER_CNT) ? pin_i : level_o; // R19
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_reg <= 2'h0;
            level_o <= 1'b0;
        end else begin
            run_reg <= (level_next != level_o) ? 2'h0 : run_next;
            level_o <= level_next;
        end
    end
endmodule : input_filter

/* hw/timer_ctl_pkg.sv */
// Behaviour
// R01: Reset clears mode and capture/compare control registers of both timers.
// R02: Mode register takes single-bit writes as well as whole-byte writes.
// R03: Counter runs when mode bits 3..2 are nonzero; 00 stops it.
// R04: Mode 00x stops and zeroes counter; output unchanged, no interrupts.
// R05: Mode 10 clears and restarts counter on first input valid edge.
// R06: Mode 11 clears on first compare match; mode 01 free-runs.
// R07: Output bit 1 clear: output toggles only on compare matches.
// R08: Output bit 1 set: first input valid edge also toggles output.
// R09: Mode bit 0 is the overflow flag, one after overflow.
// R10: Clear-on-match with compare FFFF sets overflow on FFFF to 0000 wrap.
// R11: Software stops timer before writing mode bits other than overflow.
// R12: Software writes zeros to mode bits 4 to 7.
// R13: Capcmp bit 2 makes second register compare (0) or capture (1).
// R14: Capcmp bit 1: 0 capture on second input, 1 opposite first edge.
// R15: Capcmp bit 0 makes first register compare (0) or capture (1).
// R16: Software stops timer before capcmp writes; writes zero to bits 3-7.
// R17: Software never makes first register capture in clear-on-match mode.
// R18: With both-edge selection on first input, its capture into first is off.
// R19: Input filter accepts only pulses longer than two count clocks.
// R20: Counter increments per count clock; matches raise per-register irq.
// R21: First input edge select: 00 fall, 01 rise, 11 both, 10 banned.
// R22: Overflow flag holds until software writes zero; writable while running.
package timer_ctl_pkg;
    localparam logic [31:0] TMR0_MODE_OFS = 32'hffff_f208;
    localparam logic [31:0] TMR0_CAPCMP_OFS = 32'hffff_f20a;
    localparam logic [31:0] TMR1_MODE_OFS = 32'hffff_f218;
    localparam logic [31:0] TMR1_CAPCMP_OFS = 32'hffff_f21a;
    localparam logic [31:0] TMR0_CMP0_OFS = 32'hffff_f20c;
    localparam logic [31:0] TMR0_CMP1_OFS = 32'hffff_f210;
    localparam logic [31:0] TMR0_EDGE_OFS = 32'hffff_f214;
    localparam logic [31:0] TMR0_COUNT_OFS = 32'hffff_f216;
    localparam logic [31:0] TMR_STRIDE = 32'h0000_0010;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CAPCMP_RESET = 8'h00;
    localparam logic [7:0] MODE_WMASK = 8'h0f;
    localparam logic [7:0] CAPCMP_WMASK = 8'h07;
    localparam int MODE_HI_BIT = 3;
    localparam int MODE_LO_BIT = 2;
    localparam int OUT_EDGE_BIT = 1;
    localparam int OVF_BIT = 0;
    localparam int SECOND_CAP_BIT = 2;
    localparam int FIRST_TRIG_BIT = 1;
    localparam int FIRST_CAP_BIT = 0;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    localparam logic [1:0] MODE_STOP = 2'h0;
    localparam logic [1:0] MODE_FREE = 2'h1;
    localparam logic [1:0] MODE_EDGE_CLR = 2'h2;
    localparam logic [1:0] MODE_MATCH_CLR = 2'h3;
    localparam logic [15:0] COUNT_MAX = 16'hffff;
    localparam int FILTER_CLOCKS = 2;
    localparam logic [1:0] FILTER_CNT = 2'(FILTER_CLOCKS);
    typedef struct packed {
        logic first_input;
        logic second_input;
    } pins_t;
    typedef struct packed {
        logic timer_out;
        logic first_match_irq;
        logic second_match_irq;
    } outs_t;
endpackage : timer_ctl_pkg

/* hw/timer_mode_and_capture_control.sv */
`timescale 1ns/100ps
module timer_mode_and_capture_control (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic count_tick_i,
    input wire logic [31:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] wmask_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    input wire timer_ctl_pkg::pins_t [1:0] pins_i,
    output timer_ctl_pkg::outs_t [1:0] outs_o
);
    logic [15:0] rdata_next;
    logic [15:0] rd_mux [0:1];
    logic [1:0] hit_any;

    genvar n;
    generate
        for (n = 0; n < 2; n++) begin : g_tmr
            localparam logic [31:0] BASE = timer_ctl_pkg::TMR_STRIDE *
                32'(n);
            logic [7:0] mode_ctl_reg;
            logic [7:0] mode_ctl_next;
            logic [7:0] capcmp_ctl_reg;
            logic [7:0] capcmp_ctl_next;
            logic [1:0] edge_sel_reg;
            logic [15:0] count_register;
            logic [15:0] count_next;
            logic [15:0] first_capcmp_reg;
            logic [15:0] first_next;
            logic [15:0] second_capcmp_reg;
            logic [15:0] second_next;
            logic in0_reg;
            logic in1_reg;
            logic in0_flt;
            logic in1_flt;
            logic out_reg;
            logic irq0_reg;
            logic irq1_reg;

            input_filter u_flt0 (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .tick_i(count_tick_i),
                .pin_i(pins_i[n].first_input),
                .level_o(in0_flt)
            );
            input_filter u_flt1 (
                .clock_i(clock_i),
                .rst_n_i(rst_n_i),
                .tick_i(count_tick_i),
                .pin_i(pins_i[n].second_input),
                .level_o(in1_flt)
            );

            // Address decode
            wire hit_mode = addr_i == timer_ctl_pkg::TMR0_MODE_OFS + BASE;
            wire hit_cc = addr_i == timer_ctl_pkg::TMR0_CAPCMP_OFS + BASE;
            wire hit_c0 = addr_i == timer_ctl_pkg::TMR0_CMP0_OFS + BASE;
            wire hit_c1 = addr_i == timer_ctl_pkg::TMR0_CMP1_OFS + BASE;
            wire hit_es = addr_i == timer_ctl_pkg::TMR0_EDGE_OFS + BASE;
            wire hit_cnt = addr_i == timer_ctl_pkg::TMR0_COUNT_OFS + BASE;
            assign hit_any[n] = hit_mode | hit_cc | hit_c0 | hit_c1 |
                hit_es | hit_cnt;

            // Mode fields
            wire [1:0] mode_sel = {mode_ctl_reg[timer_ctl_pkg::MODE_HI_BIT],
                mode_ctl_reg[timer_ctl_pkg::MODE_LO_BIT]};
            wire running = mode_sel != timer_ctl_pkg::MODE_STOP; // R03
            wire output_edge_trig_sel =
                mode_ctl_reg[timer_ctl_pkg::OUT_EDGE_BIT];
            wire second_reg_capture_sel =
                capcmp_ctl_reg[timer_ctl_pkg::SECOND_CAP_BIT];
            wire first_reg_trigger_sel =
                capcmp_ctl_reg[timer_ctl_pkg::FIRST_TRIG_BIT];
            wire first_reg_capture_sel =
                capcmp_ctl_reg[timer_ctl_pkg::FIRST_CAP_BIT];

            // Edge detection on filtered inputs
            wire in0_rise = in0_flt & ~in0_reg;
            wire in0_fall = ~in0_flt & in0_reg;
            wire in1_rise = in1_flt & ~in1_reg;
            wire in1_fall = ~in1_flt & in1_reg;
            wire in0_valid = (edge_sel_reg == timer_ctl_pkg::EDGE_FALL &&
                    in0_fall) ||
                (edge_sel_reg == timer_ctl_pkg::EDGE_RISE && in0_rise) ||
                (edge_sel_reg == timer_ctl_pkg::EDGE_BOTH &&
                    (in0_rise | in0_fall)); // R21
            wire in0_reverse = (edge_sel_reg == timer_ctl_pkg::EDGE_FALL &&
                    in0_rise) ||
                (edge_sel_reg == timer_ctl_pkg::EDGE_RISE && in0_fall); // R18
            wire in1_valid = (edge_sel_reg == timer_ctl_pkg::EDGE_FALL &&
                    in1_fall) ||
                (edge_sel_reg == timer_ctl_pkg::EDGE_RISE && in1_rise) ||
                (edge_sel_reg == timer_ctl_pkg::EDGE_BOTH &&
                    (in1_rise | in1_fall));

            // Counting, compare and capture
            wire step = running && count_tick_i; // R20
            wire match0 = step && !first_reg_capture_sel &&
                count_register == first_capcmp_reg; // R20
            wire match1 = step && !second_reg_capture_sel &&
                count_register == second_capcmp_reg; // R20
            wire edge_clr = running && mode_sel ==
                timer_ctl_pkg::MODE_EDGE_CLR && in0_valid; // R05
            wire match_clr = mode_sel == timer_ctl_pkg::MODE_MATCH_CLR &&
                match0; // R06
            wire wrap = step && !edge_clr &&
                count_register == timer_ctl_pkg::COUNT_MAX; // R10
            wire out_trig = match0 | match1 |
                (running && output_edge_trig_sel && in0_valid); // R07 R08
            wire cap0 = running && first_reg_capture_sel &&
                (first_reg_trigger_sel ? in0_reverse : in1_valid); // R14
            wire cap1 = running && second_reg_capture_sel &&
                in0_valid; // R13
            wire wr_mode = wr_i && hit_mode;

            assign count_next = !running ? 16'h0000 : // R04
                (edge_clr || match_clr) ? 16'h0000 : // R05 R06
                step ? count_register + 16'h0001 : count_register; // R06
            // Bit-granular writes through a lane mask
            assign mode_ctl_next = wr_mode ? ((mode_ctl_reg & ~wmask_i) |
                (wdata_i & wmask_i)) & timer_ctl_pkg::MODE_WMASK :
                mode_ctl_reg; // R02
            assign capcmp_ctl_next = (wr_i && hit_cc) ?
                ((capcmp_ctl_reg & ~wmask_i) | (wdata_i & wmask_i)) &
                timer_ctl_pkg::CAPCMP_WMASK : capcmp_ctl_reg; // R13 R15
            assign first_next = cap0 ? count_register : // R15
                (wr_i && hit_c0 && !first_reg_capture_sel) ?
                {wdata_i, wdata_i} : first_capcmp_reg;
            assign second_next = cap1 ? count_register :
                (wr_i && hit_c1 && !second_reg_capture_sel) ?
                {wdata_i, wdata_i} : second_capcmp_reg;

            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    mode_ctl_reg <= timer_ctl_pkg::MODE_RESET; // R01
                    capcmp_ctl_reg <= timer_ctl_pkg::CAPCMP_RESET; // R01
                    edge_sel_reg <= timer_ctl_pkg::EDGE_FALL;
                    count_register <= 16'h0000;
                    first_capcmp_reg <= 16'h0000;
                    second_capcmp_reg <= 16'h0000;
                    in0_reg <= 1'b0;
                    in1_reg <= 1'b0;
                    out_reg <= 1'b0;
                    irq0_reg <= 1'b0;
                    irq1_reg <= 1'b0;
                end else begin
                    mode_ctl_reg <= mode_ctl_next;
                    // Hardware set beats software clear
                    if (wrap) begin
                        mode_ctl_reg[timer_ctl_pkg::OVF_BIT] <= 1'b1; // R09
                    end
                    capcmp_ctl_reg <= capcmp_ctl_next;
                    if (wr_i && hit_es) begin
                        edge_sel_reg <= wdata_i[1:0]; // R21
                    end
                    count_register <= count_next;
                    first_capcmp_reg <= first_next;
                    second_capcmp_reg <= second_next;
                    in0_reg <= in0_flt;
                    in1_reg <= in1_flt;
                    out_reg <= out_reg ^ out_trig; // R07
                    irq0_reg <= match0 | cap0; // R20
                    irq1_reg <= match1 | cap1; // R20
                end
            end

            // Readback
            always_comb begin
                rd_mux[n] = 16'h0000;
                if (hit_mode) begin
                    rd_mux[n] = {8'h00, mode_ctl_reg}; // R09 R22
                end else if (hit_cc) begin
                    rd_mux[n] = {8'h00, capcmp_ctl_reg};
                end else if (hit_c0) begin
                    rd_mux[n] = first_capcmp_reg;
                end else if (hit_c1) begin
                    rd_mux[n] = second_capcmp_reg;
                end else if (hit_es) begin
                    rd_mux[n] = {14'h0000, edge_sel_reg};
                end else if (hit_cnt) begin
                    rd_mux[n] = count_register;
                end
            end

            assign outs_o[n].timer_out = out_reg;
            assign outs_o[n].first_match_irq = irq0_reg;
            assign outs_o[n].second_match_irq = irq1_reg;
        end
    endgenerate

    // Unmapped addresses read zero
    assign rdata_next = !rd_i ? 16'h0000 :
        hit_any[0] ? rd_mux[0] : hit_any[1] ? rd_mux[1] : 16'h0000;

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 16'h0000;
        end else begin
            rdata_o <= rdata_next;
        end
    end
endmodule : timer_mode_and_capture_control

/* testbench/timer_ctl_properties.sv */
`timescale 1ns/100ps
module timer_ctl_properties (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [31:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [7:0] wmask_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [15:0] rdata_o,
    input wire timer_ctl_pkg::outs_t [1:0] outs_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic [3:1] mode_reg;
    logic seen_reg;
    wire logic at_mode = addr_i == timer_ctl_pkg::TMR0_MODE_OFS;
    wire logic at_cc = addr_i == timer_ctl_pkg::TMR0_CAPCMP_OFS;
    wire logic at_ctl = at_mode || at_cc
        || addr_i == timer_ctl_pkg::TMR1_MODE_OFS
        || addr_i == timer_ctl_pkg::TMR1_CAPCMP_OFS;
    wire logic [3:1] mode_next = (wr_i && at_mode)
        ? (wdata_i[3:1] & wmask_i[3:1]) | (mode_reg & ~wmask_i[3:1])
        : mode_reg;
    wire logic stop = mode_reg[3:2] == 2'h0;
    wire logic irq = outs_o[0].first_match_irq || outs_o[0].second_match_irq;
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_reg <= 3'h0;
            seen_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            seen_reg <= seen_reg || wr_i;
        end
    end
    sequence s_stopped; stop [*3]; endsequence
    sequence s_wr_rd; (wr_i && at_mode) ##1 (rd_i && at_mode); endsequence
    property p_reset_zero;
        !seen_reg && rd_i && at_ctl |=> rdata_o == 16'h0000;
    endproperty
    property p_readback; s_wr_rd |=> rdata_o[3:1] == mode_reg; endproperty
    property p_mode_hi; rd_i && at_mode |=> rdata_o[15:4] == 12'h000;
    endproperty
    property p_cc_hi; rd_i && at_cc |=> rdata_o[15:3] == 13'h0000;
    endproperty
    property p_stop_quiet; s_stopped |-> !irq && $stable(outs_o[0].timer_out);
    endproperty
    property p_stop_count;
        s_stopped ##0 (rd_i && addr_i == timer_ctl_pkg::TMR0_COUNT_OFS)
        |=> rdata_o == 16'h0000;
    endproperty
    property p_toggle_cause;
        $changed(outs_o[0].timer_out) && !mode_reg[1] |-> irq;
    endproperty
    property p_irq_pulse; irq |=> !irq; endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("ctl not zero");
    a_readback: assert property (p_readback)
        else $error("mode readback");
    a_mode_hi: assert property (p_mode_hi)
        else $error("mode high bits");
    a_cc_hi: assert property (p_cc_hi)
        else $error("capcmp high bits");
    a_stop_quiet: assert property (p_stop_quiet)
        else $error("stop active");
    a_stop_count: assert property (p_stop_count)
        else $error("stop count");
    a_toggle_cause: assert property (p_toggle_cause)
        else $error("toggle");
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq length");
endmodule : timer_ctl_properties

/* testbench/timer_mode_and_capture_control_tb.sv */
`timescale 1ns/100ps
module timer_mode_and_capture_control_tb;
    localparam logic [31:0] M0 = timer_ctl_pkg::TMR0_MODE_OFS;
    localparam logic [31:0] C0 = timer_ctl_pkg::TMR0_CAPCMP_OFS;
    localparam logic [31:0] K0 = timer_ctl_pkg::TMR0_CMP0_OFS;
    localparam logic [31:0] K1 = timer_ctl_pkg::TMR0_CMP1_OFS;
    localparam logic [31:0] E0 = timer_ctl_pkg::TMR0_EDGE_OFS;
    localparam logic [31:0] T0 = timer_ctl_pkg::TMR0_COUNT_OFS;
    localparam logic [31:0] M1 = timer_ctl_pkg::TMR1_MODE_OFS;
    localparam logic [31:0] C1 = timer_ctl_pkg::TMR1_CAPCMP_OFS;
    localparam logic [31:0] REGS [5] = '{M0, C0, M1, C1, 32'hffff_f2f0};
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic count_tick_i = 1'b1;
    logic [31:0] addr_i = 32'h0000_0000;
    logic [7:0] wdata_i = 8'h00;
    logic [7:0] wmask_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [15:0] rdata_o;
    timer_ctl_pkg::pins_t [1:0] pins;
    timer_ctl_pkg::outs_t [1:0] outs_o;
    logic [15:0] v;
    logic [15:0] v0;
    logic [15:0] v1;
    logic o;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    timer_pins_model pmod (.clock_i(clock_i), .pins_o(pins));
    timer_mode_and_capture_control dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .count_tick_i(count_tick_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wmask_i(wmask_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pins_i(pins), .outs_o(outs_o));
    task automatic bus(input logic [31:0] a, input logic [7:0] d,
        input logic [7:0] m, input logic w, input logic r);
        addr_i <= a;
        wdata_i <= d;
        wmask_i <= m;
        wr_i <= w;
        rd_i <= r;
        @(posedge clock_i);
    endtask : bus
    task automatic wr(input logic [31:0] a, input logic [7:0] d,
        input logic [7:0] m);
        bus(a, d, m, 1'b1, 1'b0);
    endtask : wr
    task automatic idle(input int n);
        repeat (n) bus(32'h0000_0000, 8'h00, 8'h00, 1'b0, 1'b0);
    endtask : idle
    task automatic rd(input logic [31:0] a, output logic [15:0] q);
        bus(a, 8'h00, 8'h00, 1'b0, 1'b1);
        #1;
        q = rdata_o;
    endtask : rd
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic rchk(input logic [31:0] a, input logic [15:0] exp);
        rd(a, v);
        chk(v, exp);
    endtask : rchk
    task automatic tally_and_finish();
        if (fail_count == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 90000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        int n;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        foreach (REGS[i]) rchk(REGS[i], 16'h0000);
        wr(M1, 8'hf2, 8'hff);
        rchk(M1, 16'h0002);
        wr(C1, 8'hff, 8'hff);
        rchk(C1, 16'h0007);
        wr(K0, 8'h03, 8'hff);
        wr(K1, 8'h05, 8'hff);
        wr(M0, 8'h04, 8'h04);
        rchk(M0, 16'h0004);
        idle(1);
        n = 0;
        do begin
            @(posedge clock_i);
            #1;
            n++;
        end while (outs_o[0].first_match_irq !== 1'b1 && n < 2000);
        chk({15'h0000, outs_o[0].first_match_irq}, 16'h0001);
        chk({15'h0000, outs_o[0].timer_out}, 16'h0001);
        wr(M0, 8'h00, 8'hff);
        idle(4);
        rchk(T0, 16'h0000);
        o = outs_o[0].timer_out;
        wr(E0, 8'h01, 8'hff);
        wr(M0, 8'h08, 8'hff);
        idle(400);
        pmod.pulse(1'b0, 6);
        rd(T0, v);
        chk({15'h0000, v < 16'h0020}, 16'h0001);
        chk({15'h0000, outs_o[0].timer_out}, {15'h0000, o});
        wr(M0, 8'h00, 8'hff);
        wr(M0, 8'h06, 8'hff);
        idle(20);
        pmod.pulse(1'b0, 2);
        pmod.pulse(1'b0, 6);
        chk({15'h0000, outs_o[0].timer_out}, {15'h0000, ~o});
        wr(M0, 8'h00, 8'hff);
        wr(C0, 8'h07, 8'hff);
        wr(M0, 8'h04, 8'hff);
        idle(100);
        pmod.pulse(1'b0, 6);
        wr(M0, 8'h00, 8'hff);
        rd(K0, v0);
        rd(K1, v1);
        chk({15'h0000, v1 > 16'h0064 && v0 > v1}, 16'h0001);
        wr(E0, 8'h03, 8'hff);
        wr(M0, 8'h04, 8'hff);
        idle(20);
        pmod.pulse(1'b0, 6);
        wr(M0, 8'h00, 8'hff);
        rchk(K0, v0);
        rd(K1, v);
        chk({15'h0000, v != v1}, 16'h0001);
        // First register captures on second input edge
        wr(E0, 8'h01, 8'hff);
        wr(C0, 8'h01, 8'hff);
        wr(M0, 8'h04, 8'hff);
        idle(50);
        pmod.pulse(1'b1, 6);
        wr(M0, 8'h00, 8'hff);
        rd(K0, v);
        chk({15'h0000, v > 16'h0032 && v != v0}, 16'h0001);
        wr(C0, 8'h00, 8'hff);
        wr(K0, 8'hff, 8'hff);
        wr(M0, 8'h0c, 8'hff);
        idle(65600);
        rchk(M0, 16'h000d);
        wr(M0, 8'h00, 8'h01);
        rchk(M0, 16'h000c);
        chk({13'h0000, outs_o[1]}, 16'h0000);
        tally_and_finish();
    end
endmodule : timer_mode_and_capture_control_tb
bind timer_mode_and_capture_control timer_ctl_properties u_props (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wmask_i(wmask_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .outs_o(outs_o));

/* testbench/timer_pins_model.sv */
`timescale 1ns/100ps
module timer_pins_model (
    input wire logic clock_i,
    output timer_ctl_pkg::pins_t [1:0] pins_o
);
    initial pins_o = '0;
    // High then low, each held width count clocks
    task automatic pulse(input logic second, input int width);
        @(posedge clock_i);
        if (second) pins_o[0].second_input <= 1'b1;
        else pins_o[0].first_input <= 1'b1;
        repeat (width) @(posedge clock_i);
        pins_o[0] <= '0;
        repeat (width) @(posedge clock_i);
    endtask : pulse
endmodule : timer_pins_model
